// file: tb/ldt_panel_model.sv
// frame memory and panel receiver model
module ldt_panel_model (
	// dot clock
	input  wire logic                        i_dot_clock,
	// frame memory read port
	input  wire logic                        i_mem_rd,
	input  wire logic [ldt_pkg::ADDR_W-1:0]  i_mem_addr,
	output logic [ldt_pkg::PIXEL_W-1:0]      o_mem_data,
	// panel inputs
	input  wire logic [ldt_pkg::PIXEL_W-1:0] i_colour,
	input  wire logic                        i_strobe,
	// expected base and observations
	input  wire logic [ldt_pkg::ADDR_W-1:0]  i_base,
	output int                               o_pixels,
	output int                               o_lines,
	output int                               o_bad
);
	timeunit 1ns;
	timeprecision 100ps;
	logic strobe_q = 1'b0;
	function automatic logic [15:0] word_at(input logic [23:0] a);
		return a[15:0] ^ {a[23:16], 8'h5a};
	endfunction
	initial begin
		o_mem_data = 16'h0000;
		o_pixels = 0;
		o_lines = 0;
		o_bad = 0;
	end
	// without a read the bus shows junk, so stale data cannot pass
	always @(posedge i_dot_clock) begin
		o_mem_data <= i_mem_rd ? word_at(i_mem_addr) : ~o_mem_data;
		if (i_strobe === 1'b1) begin
			if (i_colour !== word_at(i_base + 24'(o_pixels))) begin
				o_bad <= o_bad + 1;
			end
			o_pixels <= o_pixels + 1;
		end
		if (strobe_q && i_strobe !== 1'b1) begin
			o_lines <= o_lines + 1;
		end
		strobe_q <= (i_strobe === 1'b1);
	end
endmodule // ldt_panel_model

// file: tb/ldt_timing_properties.sv
// port checks for the panel timing block
module ldt_timing_chk #(
	parameter int H_BLANK = ldt_pkg::H_BLANK_MIN
) (
	// clocks and reset
	input wire logic                        i_clock,
	input wire logic                        i_rstn,
	input wire logic                        i_dot_clock,
	// control inputs
	input wire logic                        i_base_load,
	input wire logic                        i_backlight_enable,
	input wire logic [ldt_pkg::DUTY_W-1:0]  i_backlight_duty,
	// outputs watched
	input wire logic                        o_base_ready,
	input wire logic                        o_mem_free,
	input wire logic                        o_mem_rd,
	input wire logic [ldt_pkg::ADDR_W-1:0]  o_mem_addr,
	input wire logic [ldt_pkg::PIXEL_W-1:0] o_five_six_five_colour,
	input wire logic                        o_pixel_valid_strobe,
	input wire logic                        o_hsync_n,
	input wire logic                        o_vsync_n,
	input wire logic                        o_backlight_on
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [19:0] hi_run;
	logic [19:0] lo_run;
	// low run saturates so a long idle never wraps to a short gap
	always_ff @(posedge i_dot_clock) begin
		if (!i_rstn || o_pixel_valid_strobe) begin
			lo_run <= !i_rstn ? 20'hF_FFFF : 20'h0_0000;
		end else if (lo_run != 20'hF_FFFF) begin
			lo_run <= lo_run + 20'h0_0001;
		end
	end
	always_ff @(posedge i_dot_clock) begin
		hi_run <= (i_rstn && o_pixel_valid_strobe) ? hi_run + 20'h0_0001 : 20'h0_0000;
	end
	a_sync_idle: assert property (@(posedge i_clock) o_hsync_n && o_vsync_n)
		else $error("sync output left idle level");
	a_line_len: assert property (@(posedge i_dot_clock) disable iff (!i_rstn)
		$fell(o_pixel_valid_strobe) |-> hi_run == 20'd480) else $error("line not 480 pixels");
	a_line_gap: assert property (@(posedge i_dot_clock) disable iff (!i_rstn)
		$rose(o_pixel_valid_strobe) |-> lo_run >= 20'(H_BLANK)) else $error("line gap short");
	a_frame_gap: assert property (@(posedge i_dot_clock) disable iff (!i_rstn)
		$rose(o_pixel_valid_strobe) && lo_run > 20'(ldt_pkg::H_ACTIVE + H_BLANK)
		|-> lo_run >= 20'((ldt_pkg::H_ACTIVE + H_BLANK) * ldt_pkg::V_BLANK_MIN))
		else $error("frame gap short");
	a_read_to_pixel: assert property (@(posedge i_dot_clock) disable iff (!i_rstn)
		o_mem_rd |-> ##2 o_pixel_valid_strobe) else $error("read without pixel");
	a_blank_zero: assert property (@(posedge i_dot_clock) disable iff (!i_rstn)
		!o_pixel_valid_strobe |-> o_five_six_five_colour == 16'h0000) else $error("pixel not zero");
	a_addr_step: assert property (@(posedge i_dot_clock) disable iff (!i_rstn)
		o_mem_rd && $past(o_mem_rd) |-> o_mem_addr == $past(o_mem_addr) + 24'h00_0001)
		else $error("read address not sequential");
	a_mem_quiet: assert property (@(posedge i_dot_clock) disable iff (!i_rstn)
		o_mem_rd |-> !o_mem_free) else $error("memory free while painting");
	a_bl_reset: assert property (@(posedge i_clock) !i_rstn |=> !o_backlight_on)
		else $error("backlight on in reset");
	a_bl_gate: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!i_backlight_enable [*2] |-> !o_backlight_on) else $error("backlight on while disabled");
	a_duty_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_backlight_duty == 5'h00 [*2] |-> !o_backlight_on) else $error("backlight on at zero duty");
	a_base_take: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_base_load && o_base_ready |=> !o_base_ready) else $error("base load not taken");
endmodule // ldt_timing_chk

bind ldt_timing ldt_timing_chk #(.H_BLANK(H_BLANK)) i_ldt_timing_chk (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_dot_clock(i_dot_clock), .i_base_load(i_base_load),
	.i_backlight_enable(i_backlight_enable), .i_backlight_duty(i_backlight_duty),
	.o_base_ready(o_base_ready), .o_mem_free(o_mem_free), .o_mem_rd(o_mem_rd),
	.o_mem_addr(o_mem_addr), .o_five_six_five_colour(o_five_six_five_colour),
	.o_pixel_valid_strobe(o_pixel_valid_strobe), .o_hsync_n(o_hsync_n),
	.o_vsync_n(o_vsync_n), .o_backlight_on(o_backlight_on));

// file: tb/tb_top.sv
// bench for the panel timing block
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PWM_DIV_T = 50;
	localparam int V_GAP = (ldt_pkg::H_ACTIVE + ldt_pkg::H_BLANK_MIN) * ldt_pkg::V_BLANK_MIN;
	logic        i_clock, i_rstn, i_dot_clock, i_display_enable, i_base_load;
	logic        i_backlight_enable, o_base_ready, o_mem_free, o_mem_rd;
	logic        o_pixel_valid_strobe, o_hsync_n, o_vsync_n, o_backlight_on;
	logic [4:0]  i_backlight_duty;
	logic [23:0] i_base_addr, o_mem_addr, base;
	logic [15:0] i_mem_data, o_five_six_five_colour;
	int          pixels, lines, bad, bad_count, n_tests, st_hi, drop;
	ldt_timing #(.FRAME_CYCLES(92000), .PWM_DIV(PWM_DIV_T)) i_ldt_timing (
		.i_clock(i_clock), .i_rstn(i_rstn), .i_dot_clock(i_dot_clock),
		.i_display_enable(i_display_enable), .i_base_load(i_base_load),
		.i_base_addr(i_base_addr), .o_base_ready(o_base_ready),
		.i_backlight_enable(i_backlight_enable), .i_backlight_duty(i_backlight_duty),
		.o_mem_free(o_mem_free), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
		.i_mem_data(i_mem_data), .o_five_six_five_colour(o_five_six_five_colour),
		.o_pixel_valid_strobe(o_pixel_valid_strobe), .o_hsync_n(o_hsync_n),
		.o_vsync_n(o_vsync_n), .o_backlight_on(o_backlight_on));
	ldt_panel_model i_ldt_panel_model (
		.i_dot_clock(i_dot_clock), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
		.o_mem_data(i_mem_data), .i_colour(o_five_six_five_colour),
		.i_strobe(o_pixel_valid_strobe), .i_base(base), .o_pixels(pixels),
		.o_lines(lines), .o_bad(bad));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic logic [31:0] exp_high(input logic en, input logic [4:0] d);
		if (!en) return 32'h0000_0000;
		return (d >= 5'h10) ? 32'(16 * PWM_DIV_T) : 32'(d) * 32'(PWM_DIV_T);
	endfunction
	// a whole-period window holds duty steps of high whatever its phase
	task automatic pwm_run(input logic en, input logic [4:0] d);
		int hi;
		hi = 0;
		@(posedge i_clock);
		i_backlight_enable <= en;
		i_backlight_duty <= d;
		repeat (4) @(posedge i_clock);
		repeat (16 * PWM_DIV_T) begin
			@(posedge i_clock);
			if (o_backlight_on === 1'b1) hi++;
		end
		check(hi, exp_high(en, d));
	endtask
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	initial begin
		i_dot_clock = 1'b0;
		#1.3;
		forever #3 i_dot_clock = ~i_dot_clock;
	end
	initial begin
		repeat (120000) @(posedge i_clock);
		bad_count++;
		end_sim();
	end
	initial begin
		{i_rstn, i_display_enable, i_base_load, i_backlight_enable} = 4'h0;
		{i_backlight_duty, i_base_addr} = '0;
		{bad_count, n_tests} = '0;
		void'($urandom(22));
		base = 24'($urandom()) & 24'h7F_FFFF;
		repeat (6) @(posedge i_clock);
		check({o_backlight_on, o_mem_free, o_base_ready, o_hsync_n, o_vsync_n}, 32'h7);
		repeat (2) @(posedge i_clock);
		i_rstn <= 1'b1;
		i_backlight_enable <= 1'b1;
		i_backlight_duty <= 5'h10;
		repeat (100) @(posedge i_clock);
		check(o_backlight_on, 1'b0);
		i_base_addr <= base;
		i_base_load <= 1'b1;
		@(posedge i_clock);
		// second load lands while busy and must be ignored
		i_base_addr <= ~base;
		@(posedge i_clock);
		i_base_load <= 1'b0;
		for (int i = 0; i < 100 && o_base_ready !== 1'b1; i++) @(posedge i_clock);
		check(o_base_ready, 1'b1);
		pwm_run(1'b1, 5'h00);
		pwm_run(1'b1, 5'h10);
		pwm_run(1'b0, 5'h10);
		pwm_run(1'b1, 5'h1f);
		repeat (4) pwm_run(1'b1, 5'($urandom_range(31)));
		i_display_enable <= 1'b1;
		for (int i = 0; i < 100000 && lines < 272; i++) @(posedge i_clock);
		check(lines, 272);
		check(pixels, 480 * 272);
		check(bad, 0);
		for (int i = 0; i < 100 && o_mem_free !== 1'b1; i++) @(posedge i_clock);
		check(o_mem_free, 1'b1);
		{st_hi, drop} = '0;
		repeat (V_GAP) begin
			@(posedge i_dot_clock);
			if (o_pixel_valid_strobe !== 1'b0) st_hi++;
			if (o_mem_free !== 1'b1) drop++;
		end
		check(st_hi, 0);
		check(drop, 0);
		i_display_enable <= 1'b0;
		end_sim();
	end
endmodule // tb_top

// file: verilog/ldt_backlight_pwm.sv
// backlight dimming modulator with a slow step clock
module ldt_backlight_pwm #(
	parameter int DIV_CYCLES = ldt_pkg::PWM_DIV_CYCLES
) (
	// clock and reset
	input  wire logic                      i_clock,
	input  wire logic                      i_rstn,
	// control
	input  wire logic                      i_enable,
	input  wire logic [ldt_pkg::DUTY_W-1:0] i_duty,
	// backlight
	output logic                           o_pwm
);
	logic [ldt_pkg::DIV_W-1:0] div_cnt;
	logic [3:0]                step;
	logic                      step_tick;

	// step clock at most 16 kHz; a shorter divider would break that
	assign step_tick = (div_cnt == ldt_pkg::DIV_W'(DIV_CYCLES - 1));

	always_ff @(posedge i_clock) begin
		if (!i_rstn || step_tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// 16 steps per period: 1 kHz steps give a 62.5 Hz frame
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			step <= 4'h0;
		end else if (step_tick) begin
			step <= step + 4'h1;
		end
	end

	// duty 0 is dark, 16 and above is fully on
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_pwm <= 1'b0;
		end else begin
			o_pwm <= i_enable && ({1'b0, step} < i_duty);
		end
	end
endmodule // ldt_backlight_pwm

// file: verilog/ldt_pkg.sv
// constants for the panel timing and pixel streaming block
package ldt_pkg;
	localparam int PIXEL_W        = 16;
	localparam int H_ACTIVE       = 480;
	localparam int V_ACTIVE       = 272;
	localparam int H_BLANK_MIN    = 45;
	localparam int V_BLANK_MIN    = 13;
	localparam int COORD_W        = 9;
	localparam int ADDR_W         = 24;
	// five_six_five_colour field positions
	localparam int RED_LSB        = 11;
	localparam int GREEN_LSB      = 5;
	localparam int BLUE_LSB       = 0;
	localparam int SYS_CLK_HZ     = 100_000_000;
	localparam int FRAME_RATE_HZ  = 60;
	localparam int PAINT_MS       = 8;
	localparam int PWM_CLK_HZ     = 1_000;
	localparam int PWM_CLK_MAX_HZ = 16_000;
	localparam int PWM_STEPS      = 16;
	localparam int DUTY_W         = 5;
	// divider rounds up so the step clock never exceeds its rate
	localparam int PWM_DIV_CYCLES = (SYS_CLK_HZ + PWM_CLK_HZ - 1) / PWM_CLK_HZ;
	localparam int PWM_DIV_MIN    = (SYS_CLK_HZ + PWM_CLK_MAX_HZ - 1) / PWM_CLK_MAX_HZ;
	localparam int FRAME_CYCLES   = SYS_CLK_HZ / FRAME_RATE_HZ;
	localparam int DIV_W          = 24;
	localparam logic [ADDR_W-1:0]  BASE_RESET  = 24'h00_0000;
	localparam logic [PIXEL_W-1:0] PIXEL_IDLE  = 16'h0000;
	localparam logic [DUTY_W-1:0]  DUTY_RESET  = 5'h00;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_HBLANK,
		ST_VBLANK
	} ldt_state_t;
endpackage

// file: verilog/ldt_timing.sv
// panel timing generator, pixel fetch and backlight control
module ldt_timing #(
	parameter int H_BLANK      = ldt_pkg::H_BLANK_MIN,
	parameter int V_BLANK      = ldt_pkg::V_BLANK_MIN,
	parameter int FRAME_CYCLES = ldt_pkg::FRAME_CYCLES,
	parameter int PWM_DIV      = ldt_pkg::PWM_DIV_CYCLES
) (
	// system clock and reset
	input  wire logic                        i_clock,
	input  wire logic                        i_rstn,
	// dot clock of the panel link
	input  wire logic                        i_dot_clock,
	// configuration, system domain
	input  wire logic                        i_display_enable,
	input  wire logic                        i_base_load,
	input  wire logic [ldt_pkg::ADDR_W-1:0]  i_base_addr,
	output logic                             o_base_ready,
	input  wire logic                        i_backlight_enable,
	input  wire logic [ldt_pkg::DUTY_W-1:0]  i_backlight_duty,
	// frame memory status, system domain
	output logic                             o_mem_free,
	// frame memory read port, dot domain
	output logic                             o_mem_rd,
	output logic [ldt_pkg::ADDR_W-1:0]       o_mem_addr,
	input  wire logic [ldt_pkg::PIXEL_W-1:0] i_mem_data,
	// panel, dot domain; backlight on the system clock
	output logic [ldt_pkg::PIXEL_W-1:0]      o_five_six_five_colour,
	output logic                             o_pixel_valid_strobe,
	output logic                             o_hsync_n,
	output logic                             o_vsync_n,
	output logic                             o_backlight_on
);
	localparam int LINE_LEN = ldt_pkg::H_ACTIVE + H_BLANK;
	localparam int CNT_W    = 12;

	// system domain state
	logic                       en_sys;
	logic [ldt_pkg::ADDR_W-1:0] base_hold;
	logic                       base_req;
	logic                       ack_meta;
	logic                       ack_sync;
	logic                       base_loaded;
	logic [ldt_pkg::DIV_W-1:0]  frame_cnt;
	logic                       frame_tgl;
	logic                       frame_tick;
	logic                       free_meta;
	logic                       free_sync;
	logic                       starting;

	// dot domain state
	logic                        dot_rstn_meta;
	logic                        dot_rstn;
	logic                        en_meta;
	logic                        en_dot;
	logic                        req_meta;
	logic                        req_sync;
	logic                        base_ack;
	logic                        tgl_meta;
	logic                        tgl_sync;
	logic                        tgl_prev;
	logic                        frame_pending;
	logic                        base_valid;
	logic [ldt_pkg::ADDR_W-1:0]  base_shadow;
	ldt_pkg::ldt_state_t         state;
	logic [ldt_pkg::COORD_W-1:0] x_pos;
	logic [ldt_pkg::COORD_W-1:0] y_pos;
	logic [CNT_W-1:0]            blank_cnt;
	logic [CNT_W-1:0]            vline_cnt;
	logic [ldt_pkg::ADDR_W-1:0]  fetch_addr;
	logic                        fetch_d1;
	logic                        free_dot;
	logic                        start_frame;
	logic                        line_end;

	assign o_hsync_n = 1'b1;
	assign o_vsync_n = 1'b1;

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			en_sys    <= 1'b0;
			ack_meta  <= 1'b0;
			ack_sync  <= 1'b0;
			free_meta <= 1'b0;
			free_sync <= 1'b0;
		end else begin
			en_sys    <= i_display_enable;
			ack_meta  <= base_ack;
			ack_sync  <= ack_meta;
			free_meta <= free_dot;
			free_sync <= free_meta;
		end
	end

	// base address crosses by toggle handshake; hold stays put until ack
	assign o_base_ready = (base_req == ack_sync);

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			base_hold <= ldt_pkg::BASE_RESET;
			base_req  <= 1'b0;
		end else if (i_base_load && o_base_ready) begin
			base_hold <= i_base_addr;
			base_req  <= ~base_req;
		end
	end

	// configured once a frame base has landed in the dot domain
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			base_loaded <= 1'b0;
		end else if (o_base_ready && (base_req != 1'b0 || base_loaded)) begin
			base_loaded <= 1'b1;
		end
	end

	// ticks only while running; parked at the end so enabling launches at once
	assign frame_tick = en_sys && base_loaded && frame_cnt == ldt_pkg::DIV_W'(FRAME_CYCLES - 1);

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			frame_cnt <= ldt_pkg::DIV_W'(FRAME_CYCLES - 1);
			frame_tgl <= 1'b0;
		end else if (!en_sys || !base_loaded) begin
			frame_cnt <= ldt_pkg::DIV_W'(FRAME_CYCLES - 1);
		end else if (frame_tick) begin
			frame_cnt <= '0;
			frame_tgl <= ~frame_tgl;
		end else begin
			frame_cnt <= frame_cnt + 1'b1;
		end
	end

	// drop the free flag at launch, ahead of the synchronised status
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			starting <= 1'b0;
		end else if (frame_tick && en_sys && base_loaded) begin
			starting <= 1'b1;
		end else if (!free_sync || !en_sys) begin
			starting <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_mem_free <= 1'b0;
		end else begin
			o_mem_free <= free_sync && !starting && !(frame_tick && en_sys && base_loaded);
		end
	end

	ldt_backlight_pwm #(
		.DIV_CYCLES (PWM_DIV)
	) u_pwm (
		.i_clock  (i_clock),
		.i_rstn   (i_rstn),
		.i_enable (i_backlight_enable && base_loaded),
		.i_duty   (i_backlight_duty),
		.o_pwm    (o_backlight_on)
	);

	always_ff @(posedge i_dot_clock) begin
		dot_rstn_meta <= i_rstn;
		dot_rstn      <= dot_rstn_meta;
	end

	always_ff @(posedge i_dot_clock) begin
		if (!dot_rstn) begin
			en_meta  <= 1'b0;
			en_dot   <= 1'b0;
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
			tgl_prev <= 1'b0;
		end else begin
			en_meta  <= en_sys;
			en_dot   <= en_meta;
			req_meta <= base_req;
			req_sync <= req_meta;
			tgl_meta <= frame_tgl;
			tgl_sync <= tgl_meta;
			tgl_prev <= tgl_sync;
		end
	end

	// shadow only feeds the fetch at frame start, so no tearing
	always_ff @(posedge i_dot_clock) begin
		if (!dot_rstn) begin
			base_shadow <= ldt_pkg::BASE_RESET;
			base_ack    <= 1'b0;
			base_valid  <= 1'b0;
		end else if (req_sync != base_ack) begin
			base_shadow <= base_hold;
			base_ack    <= req_sync;
			base_valid  <= 1'b1;
		end
	end

	assign start_frame = (state == ldt_pkg::ST_IDLE) && frame_pending && en_dot && base_valid;
	assign line_end    = (blank_cnt == CNT_W'(LINE_LEN - 1));

	// a tick arriving in the cycle a frame starts is kept: set wins
	always_ff @(posedge i_dot_clock) begin
		if (!dot_rstn) begin
			frame_pending <= 1'b0;
		end else if (tgl_sync != tgl_prev) begin
			frame_pending <= 1'b1;
		end else if (start_frame) begin
			frame_pending <= 1'b0;
		end
	end

	always_ff @(posedge i_dot_clock) begin
		if (!dot_rstn) begin
			state     <= ldt_pkg::ST_IDLE;
			x_pos     <= '0;
			y_pos     <= '0;
			blank_cnt <= '0;
			vline_cnt <= '0;
		end else begin
			case (state)
				ldt_pkg::ST_IDLE: begin
					x_pos     <= '0;
					y_pos     <= '0;
					blank_cnt <= '0;
					vline_cnt <= '0;
					if (start_frame) begin
						state <= ldt_pkg::ST_ACTIVE;
					end
				end
				ldt_pkg::ST_ACTIVE: begin
					blank_cnt <= '0;
					if (x_pos == ldt_pkg::COORD_W'(ldt_pkg::H_ACTIVE - 1)) begin
						x_pos <= '0;
						if (y_pos == ldt_pkg::COORD_W'(ldt_pkg::V_ACTIVE - 1)) begin
							state <= ldt_pkg::ST_VBLANK;
						end else begin
							state <= ldt_pkg::ST_HBLANK;
						end
					end else begin
						x_pos <= x_pos + 1'b1;
					end
				end
				ldt_pkg::ST_HBLANK: begin
					if (blank_cnt == CNT_W'(H_BLANK - 1)) begin
						state     <= ldt_pkg::ST_ACTIVE;
						blank_cnt <= '0;
						y_pos     <= y_pos + 1'b1;
					end else begin
						blank_cnt <= blank_cnt + 1'b1;
					end
				end
				ldt_pkg::ST_VBLANK: begin
					// whole line periods of silence before the next frame
					if (line_end) begin
						blank_cnt <= '0;
						if (vline_cnt == CNT_W'(V_BLANK - 1)) begin
							state <= ldt_pkg::ST_IDLE;
						end else begin
							vline_cnt <= vline_cnt + 1'b1;
						end
					end else begin
						blank_cnt <= blank_cnt + 1'b1;
					end
				end
				default: begin
					state <= ldt_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// raster order: one word per pixel, consecutive from the base
	always_ff @(posedge i_dot_clock) begin
		if (!dot_rstn) begin
			fetch_addr <= ldt_pkg::BASE_RESET;
		end else if (start_frame) begin
			fetch_addr <= base_shadow;
		end else if (state == ldt_pkg::ST_ACTIVE) begin
			fetch_addr <= fetch_addr + 1'b1;
		end
	end

	always_ff @(posedge i_dot_clock) begin
		if (!dot_rstn) begin
			o_mem_rd   <= 1'b0;
			o_mem_addr <= ldt_pkg::BASE_RESET;
		end else begin
			o_mem_rd   <= (state == ldt_pkg::ST_ACTIVE);
			o_mem_addr <= fetch_addr;
		end
	end

	// memory answers one dot clock after the read; strobe follows the data
	always_ff @(posedge i_dot_clock) begin
		if (!dot_rstn) begin
			fetch_d1               <= 1'b0;
			o_pixel_valid_strobe   <= 1'b0;
			o_five_six_five_colour <= ldt_pkg::PIXEL_IDLE;
		end else begin
			fetch_d1             <= o_mem_rd;
			o_pixel_valid_strobe <= fetch_d1;
			if (fetch_d1) begin
				o_five_six_five_colour <= i_mem_data;
			end else begin
				o_five_six_five_colour <= ldt_pkg::PIXEL_IDLE;
			end
		end
	end

	// free only once the last read of the frame has left the port
	always_ff @(posedge i_dot_clock) begin
		if (!dot_rstn) begin
			free_dot <= 1'b0;
		end else begin
			free_dot <= (state == ldt_pkg::ST_VBLANK || state == ldt_pkg::ST_IDLE)
				&& !start_frame && !o_mem_rd;
		end
	end
endmodule // ldt_timing
